/* File: src/cogsc_top.sv */
// power-good/power-down control, output gating and two-wire config slave
// assumes all pins are asynchronous; the slave never stretches the clock line
// Overview of operation
// - power-good low at startup keeps outputs off
// - after power-good seen, low pin means standby
// - power-down stops outputs cleanly, held low
// - standby also stops oscillator and serial slave
// - release restarts outputs within two-six cycles
// - output runs only when pin and bit high
// - restart gives only whole clock pulses
// - enable to active output within six cycles
// - disabled output stops cleanly, then held low
// - spread select sampled, drives downward spread
// - registers take defaults at power-up
// - byte and block reads and writes
// - block bytes ascend, stop after any byte
// - command code carries the register index
// - answer only to own address pattern
// - block write: address, command, count, data
// - block read returns count, then data bytes
// - byte write: address, command, one data
// - byte read: address, command, one data back
// - register one holds four output enables
// - byte count register defaults to six
module cogsc_top #(
  parameter int REF_HALF = cogsc_pkg::REF_HALF_CYC
) (
  input  wire logic       clk_in,
  input  wire logic       reset_n_in,
  input  wire logic       power_good_or_powerdown_pin_in,
  input  wire logic       spread_select_input_in,
  input  wire logic [3:0] oe_pins_in,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out_out,
  output logic            sda_oe_out,
  output logic [3:0]      differential_clock_outputs_out,
  output logic            spread_enable_out,
  output logic            osc_enable_out
);
  localparam logic [7:0] HALF_M1 = 8'(REF_HALF - 1);

  cogsc_pkg::cogsc_top_st_t s_r;
  cogsc_pkg::cogsc_top_st_t s_nxt;
  cogsc_pkg::cogsc_pins_t   pins;
  logic                     standby;
  logic                     scl_rise;
  logic                     scl_fall;
  logic                     bus_start;
  logic                     bus_stop;
  logic                     ref_run;
  logic                     ref_rise;
  logic                     ref_fall;
  logic [3:0]               en_bits;
  logic [3:0]               en_req;
  logic [3:0]               gate_open;
  logic [7:0]               tx_byte;
  logic                     tx_is_cnt;

  function automatic logic [7:0] rd_reg(cogsc_pkg::cogsc_regs_t r, logic [6:0] idx);
    logic [7:0] d;
    d = 8'h00;
    case (idx)
      cogsc_pkg::IDX_CFG0:   d = r.cfg0;
      cogsc_pkg::IDX_OE_LOW: d = r.oe_low;
      cogsc_pkg::IDX_BCNT:   d = r.bcnt;
      default:               d = 8'h00;
    endcase
    return d;
  endfunction

  function automatic cogsc_pkg::cogsc_regs_t wr_reg(cogsc_pkg::cogsc_regs_t r,
                                                    logic [6:0] idx, logic [7:0] d);
    cogsc_pkg::cogsc_regs_t w;
    w = r;
    case (idx)
      cogsc_pkg::IDX_CFG0:   w.cfg0 = d;
      cogsc_pkg::IDX_OE_LOW: w.oe_low = d;
      cogsc_pkg::IDX_BCNT:   w.bcnt = d;
      default:               w = r;
    endcase
    return w;
  endfunction

  assign pins = '{scl: scl_in, sda: sda_in, pg_pin: power_good_or_powerdown_pin_in,
                  spread: spread_select_input_in, oe: oe_pins_in};

  // edges are taken between the second and third stages only
  assign scl_rise  = s_r.p2.scl & ~s_r.p3.scl;
  assign scl_fall  = ~s_r.p2.scl & s_r.p3.scl;
  assign bus_start = s_r.p2.scl & s_r.p3.scl & s_r.p3.sda & ~s_r.p2.sda;
  assign bus_stop  = s_r.p2.scl & s_r.p3.scl & ~s_r.p3.sda & s_r.p2.sda;

  assign standby = s_r.pg_seen & ~s_r.p2.pg_pin;

  // oscillator keeps running until every gate has closed at a low phase
  assign ref_run  = ~standby | (|gate_open) | s_r.ref_clk;
  assign ref_rise = ref_run & (s_r.div == HALF_M1) & ~s_r.ref_clk;
  assign ref_fall = ref_run & (s_r.div == HALF_M1) & s_r.ref_clk;

  assign en_bits[0] = s_r.regs.oe_low[cogsc_pkg::OUT0_POS];
  assign en_bits[1] = s_r.regs.oe_low[cogsc_pkg::OUT1_POS];
  assign en_bits[2] = s_r.regs.oe_low[cogsc_pkg::OUT2_POS];
  assign en_bits[3] = s_r.regs.oe_low[cogsc_pkg::OUT3_POS];
  assign en_req = s_r.p2.oe & en_bits & {4{s_r.pg_seen & ~standby}};

  // block read sends the count first, then ascending registers
  assign tx_is_cnt = s_r.first_tx & ~s_r.byte_mode;
  assign tx_byte   = tx_is_cnt ? s_r.regs.bcnt : rd_reg(s_r.regs, s_r.ptr);

  always_comb
  begin
    s_nxt    = s_r;
    s_nxt.p1 = pins;
    s_nxt.p2 = s_r.p1;
    s_nxt.p3 = s_r.p2;
    if (s_r.p2.pg_pin)
    begin
      s_nxt.pg_seen = 1'b1;
    end
    s_nxt.spread = s_r.p2.spread;
    if (ref_run)
    begin
      if (s_r.div == HALF_M1)
      begin
        s_nxt.div     = 8'h00;
        s_nxt.ref_clk = ~s_r.ref_clk;
      end
      else
      begin
        s_nxt.div = s_r.div + 8'h01;
      end
    end
    if (standby)
    begin
      s_nxt.fsm    = cogsc_pkg::S_IDLE;
      s_nxt.sda_oe = 1'b0;
    end
    else if (bus_start)
    begin
      s_nxt.fsm    = cogsc_pkg::S_RX;
      s_nxt.cnt    = 4'h0;
      s_nxt.bidx   = cogsc_pkg::BIDX_ADDR;
      s_nxt.sda_oe = 1'b0;
    end
    else if (bus_stop)
    begin
      s_nxt.fsm    = cogsc_pkg::S_IDLE;
      s_nxt.sda_oe = 1'b0;
    end
    else
    begin
      case (s_r.fsm)
        cogsc_pkg::S_IDLE:
        begin
          s_nxt.sda_oe = 1'b0;
        end
        cogsc_pkg::S_RX:
        begin
          if (scl_rise)
          begin
            s_nxt.sh  = {s_r.sh[6:0], s_r.p2.sda};
            s_nxt.cnt = s_r.cnt + 4'h1;
          end
          else if (scl_fall && s_r.cnt == cogsc_pkg::BITS_BYTE)
          begin
            s_nxt.cnt    = 4'h0;
            s_nxt.fsm    = cogsc_pkg::S_ACK;
            s_nxt.sda_oe = 1'b1;
            s_nxt.bidx   = (s_r.bidx == cogsc_pkg::BIDX_DATA) ? s_r.bidx
                                                               : s_r.bidx + 2'h1;
            case (s_r.bidx)
              cogsc_pkg::BIDX_ADDR:
              begin
                s_nxt.rw       = s_r.sh[0];
                s_nxt.first_tx = 1'b1;
                if (s_r.sh[7:1] != cogsc_pkg::SLV_ADDR7)
                begin
                  s_nxt.fsm    = cogsc_pkg::S_IDLE;
                  s_nxt.sda_oe = 1'b0;
                end
              end
              cogsc_pkg::BIDX_CMD:
              begin
                s_nxt.byte_mode = s_r.sh[cogsc_pkg::CMD_MODE_POS];
                s_nxt.ptr       = s_r.sh[6:0];
              end
              cogsc_pkg::BIDX_CNT:
              begin
                // block count byte is only acknowledged, never stored
                if (s_r.byte_mode)
                begin
                  s_nxt.regs = wr_reg(s_r.regs, s_r.ptr, s_r.sh);
                  s_nxt.ptr  = s_r.ptr + 7'h01;
                end
              end
              default:
              begin
                s_nxt.regs = wr_reg(s_r.regs, s_r.ptr, s_r.sh);
                s_nxt.ptr  = s_r.ptr + 7'h01;
              end
            endcase
          end
        end
        cogsc_pkg::S_ACK:
        begin
          if (scl_fall)
          begin
            if (s_r.rw)
            begin
              s_nxt.sh       = tx_byte;
              s_nxt.sda_oe   = ~tx_byte[7];
              s_nxt.cnt      = 4'h0;
              s_nxt.first_tx = 1'b0;
              s_nxt.fsm      = cogsc_pkg::S_TX;
              if (!tx_is_cnt)
              begin
                s_nxt.ptr = s_r.ptr + 7'h01;
              end
            end
            else
            begin
              s_nxt.sda_oe = 1'b0;
              s_nxt.fsm    = cogsc_pkg::S_RX;
            end
          end
        end
        cogsc_pkg::S_TX:
        begin
          if (scl_fall)
          begin
            if (s_r.cnt == cogsc_pkg::LAST_TX_BIT)
            begin
              s_nxt.sda_oe = 1'b0;
              s_nxt.fsm    = cogsc_pkg::S_MACK;
            end
            else
            begin
              s_nxt.sh     = {s_r.sh[6:0], 1'b0};
              s_nxt.sda_oe = ~s_r.sh[6];
              s_nxt.cnt    = s_r.cnt + 4'h1;
            end
          end
        end
        cogsc_pkg::S_MACK:
        begin
          if (scl_rise)
          begin
            s_nxt.mack = ~s_r.p2.sda;
          end
          else if (scl_fall)
          begin
            if (s_r.mack)
            begin
              s_nxt.sh       = tx_byte;
              s_nxt.sda_oe   = ~tx_byte[7];
              s_nxt.cnt      = 4'h0;
              s_nxt.first_tx = 1'b0;
              s_nxt.fsm      = cogsc_pkg::S_TX;
              if (!tx_is_cnt)
              begin
                s_nxt.ptr = s_r.ptr + 7'h01;
              end
            end
            else
            begin
              s_nxt.fsm = cogsc_pkg::S_IDLE;
            end
          end
        end
        default:
        begin
          s_nxt.fsm    = cogsc_pkg::S_IDLE;
          s_nxt.sda_oe = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      s_r              <= '0;
      s_r.fsm          <= cogsc_pkg::S_IDLE;
      // link stages start at the idle level, so no false edge follows reset
      s_r.p1.scl       <= 1'b1;
      s_r.p1.sda       <= 1'b1;
      s_r.p2.scl       <= 1'b1;
      s_r.p2.sda       <= 1'b1;
      s_r.p3.scl       <= 1'b1;
      s_r.p3.sda       <= 1'b1;
      s_r.regs.cfg0    <= cogsc_pkg::RST_CFG0;
      s_r.regs.oe_low  <= cogsc_pkg::RST_OE_LOW;
      s_r.regs.bcnt    <= cogsc_pkg::RST_BCNT;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  for (genvar i = 0; i < 4; i++)
  begin : g_out
    cogsc_gate u_gate (
      .clk_in      (clk_in),
      .reset_n_in  (reset_n_in),
      .ref_rise_in (ref_rise),
      .ref_fall_in (ref_fall),
      .en_req_in   (en_req[i]),
      .clk_out     (differential_clock_outputs_out[i]),
      .open_out    (gate_open[i])
    );
  end

  assign sda_out_out       = 1'b0;
  assign sda_oe_out        = s_r.sda_oe;
  assign spread_enable_out = s_r.spread;
  assign osc_enable_out    = ref_run;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);

  AST_PG_HOLD: assert property (!s_r.pg_seen |-> differential_clock_outputs_out == 4'h0)
    else $error("output running before power-good was seen");
  AST_PG_LATCH: assert property (s_r.p2.pg_pin |=> s_r.pg_seen ##1 s_r.pg_seen)
    else $error("power-good high not latched");
  AST_PD_STOP: assert property ($rose(standby) |-> ##[1:40] (gate_open == 4'h0))
    else $error("outputs not stopped after power-down");
  AST_PD_SLAVE: assert property (standby |=> !sda_oe_out && s_r.fsm == cogsc_pkg::S_IDLE)
    else $error("serial slave active in standby");
  AST_ADDR_MISS: assert property ((s_r.fsm == cogsc_pkg::S_RX && scl_fall && !standby
      && !bus_start && !bus_stop && s_r.cnt == cogsc_pkg::BITS_BYTE
      && s_r.bidx == cogsc_pkg::BIDX_ADDR && s_r.sh[7:1] != cogsc_pkg::SLV_ADDR7)
      |=> s_r.fsm == cogsc_pkg::S_IDLE && !sda_oe_out)
    else $error("foreign address answered");
  AST_IDLE_FREE: assert property (s_r.fsm == cogsc_pkg::S_IDLE |-> !sda_oe_out)
    else $error("data line driven while idle");
  AST_REG_DEFAULT: assert property ($rose(reset_n_in) |-> s_r.regs.oe_low == cogsc_pkg::RST_OE_LOW
      && s_r.regs.bcnt == cogsc_pkg::RST_BCNT)
    else $error("register defaults wrong after reset");
  AST_SPREAD: assert property ($changed(s_r.p2.spread) |=> spread_enable_out == $past(s_r.p2.spread))
    else $error("spread select not followed");
endmodule

/* File: shared/cogsc_pkg.sv */
// constants, state types and carriers for the clock output gating block
// assumes a single 10 MHz core clock; pins are asynchronous to it
package cogsc_pkg;
  localparam logic [6:0] SLV_ADDR7    = 7'h6b;
  localparam logic [6:0] IDX_CFG0     = 7'h00;
  localparam logic [6:0] IDX_OE_LOW   = 7'h01;
  localparam logic [6:0] IDX_BCNT     = 7'h04;
  localparam logic [7:0] RST_CFG0     = 8'h00;
  localparam logic [7:0] RST_OE_LOW   = 8'h17;
  localparam logic [7:0] RST_BCNT     = 8'h06;
  localparam int         OUT0_POS     = 4;
  localparam int         OUT1_POS     = 2;
  localparam int         OUT2_POS     = 1;
  localparam int         OUT3_POS     = 0;
  localparam int         CMD_MODE_POS = 7;
  localparam logic [3:0] BITS_BYTE    = 4'h8;
  localparam logic [3:0] LAST_TX_BIT  = 4'h7;
  localparam logic [1:0] BIDX_ADDR    = 2'h0;
  localparam logic [1:0] BIDX_CMD     = 2'h1;
  localparam logic [1:0] BIDX_CNT     = 2'h2;
  localparam logic [1:0] BIDX_DATA    = 2'h3;
  localparam logic [1:0] CNT_SAT      = 2'h3;
  localparam int         REF_HALF_CYC = 2;

  typedef enum logic [2:0] {S_IDLE, S_RX, S_ACK, S_TX, S_MACK} cogsc_i2c_st_t;

  typedef struct packed {
    logic [7:0] cfg0;
    logic [7:0] oe_low;
    logic [7:0] bcnt;
  } cogsc_regs_t;

  typedef struct packed {
    logic       scl;
    logic       sda;
    logic       pg_pin;
    logic       spread;
    logic [3:0] oe;
  } cogsc_pins_t;

  typedef struct packed {
    cogsc_pins_t   p1;
    cogsc_pins_t   p2;
    cogsc_pins_t   p3;
    logic          pg_seen;
    logic          spread;
    logic          ref_clk;
    logic [7:0]    div;
    cogsc_regs_t   regs;
    cogsc_i2c_st_t fsm;
    logic [7:0]    sh;
    logic [3:0]    cnt;
    logic [1:0]    bidx;
    logic          rw;
    logic          byte_mode;
    logic [6:0]    ptr;
    logic          first_tx;
    logic          mack;
    logic          sda_oe;
  } cogsc_top_st_t;

  typedef struct packed {
    logic       en1;
    logic       gate;
    logic       out;
    logic [1:0] wait_cnt;
    logic [1:0] off_cnt;
  } cogsc_gate_st_t;
endpackage

/* File: src/cogsc_gate.sv */
// one output clock gate: starts and stops only on the low phase
// assumes ref_rise_in / ref_fall_in are one-cycle pulses of the internal reference
module cogsc_gate (
  input  wire logic clk_in,
  input  wire logic reset_n_in,
  input  wire logic ref_rise_in,
  input  wire logic ref_fall_in,
  input  wire logic en_req_in,
  output logic      clk_out,
  output logic      open_out
);
  cogsc_pkg::cogsc_gate_st_t s_r;
  cogsc_pkg::cogsc_gate_st_t s_nxt;

  always_comb
  begin
    s_nxt = s_r;
    // gate changes only at a falling edge, so no pulse is cut or stretched
    if (ref_fall_in)
    begin
      s_nxt.en1  = en_req_in;
      s_nxt.gate = s_r.en1;
      s_nxt.out  = 1'b0;
    end
    else if (ref_rise_in)
    begin
      s_nxt.out = s_r.gate;
    end
    // helper counts, watched by the checks below
    if (en_req_in && !s_r.gate)
    begin
      if (ref_rise_in && s_r.wait_cnt != cogsc_pkg::CNT_SAT)
      begin
        s_nxt.wait_cnt = s_r.wait_cnt + 2'h1;
      end
    end
    else
    begin
      s_nxt.wait_cnt = 2'h0;
    end
    if (!en_req_in && s_r.gate)
    begin
      if (ref_fall_in && s_r.off_cnt != cogsc_pkg::CNT_SAT)
      begin
        s_nxt.off_cnt = s_r.off_cnt + 2'h1;
      end
    end
    else
    begin
      s_nxt.off_cnt = 2'h0;
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      s_r <= '0;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign clk_out  = s_r.out;
  assign open_out = s_r.gate;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);

  AST_START_FULL: assert property ($rose(s_r.out) |-> s_r.gate && $past(ref_rise_in))
    else $error("output started outside a rising reference edge");
  AST_STOP_LOW: assert property (!s_r.gate |=> !s_r.out)
    else $error("closed output is not held low");
  AST_START_LATENCY: assert property (s_r.wait_cnt != cogsc_pkg::CNT_SAT)
    else $error("enable to running output took over two rising edges");
  AST_STOP_LATENCY: assert property (s_r.off_cnt != cogsc_pkg::CNT_SAT)
    else $error("disabled output kept running past two falling edges");
endmodule

/* File: sim/cogsc_host.sv */
// two-wire controller model facing the config slave
// assumes the bench calls its tasks one at a time; data line has a pull-up
module cogsc_host (
  input  wire logic clk_in,
  input  wire logic dev_oe_in,
  input  wire logic dev_out_in,
  output logic      scl_out,
  output wire logic sda_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic m_oe;
  // pull-up: a released line reads high, never the last value
  assign sda_out = ~(m_oe | (dev_oe_in & ~dev_out_in));
  initial
  begin
    scl_out = 1'b1;
    m_oe = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  // start or repeated start; clock line then left low
  task automatic start_cond();
    @(posedge clk_in);
    m_oe <= 1'b0;
    tick(2);
    scl_out <= 1'b1;
    tick(2);
    m_oe <= 1'b1;
    tick(2);
    scl_out <= 1'b0;
    tick(2);
  endtask
  // clock stands high after stop, link idle
  task automatic stop_cond();
    @(posedge clk_in);
    m_oe <= 1'b1;
    tick(2);
    scl_out <= 1'b1;
    tick(2);
    m_oe <= 1'b0;
    tick(4);
  endtask
  // data set mid low phase, sampled late in high phase for slow answers
  task automatic bit_io(input logic b, output logic r);
    m_oe <= ~b;
    tick(2);
    scl_out <= 1'b1;
    tick(3);
    r = sda_out;
    tick(1);
    scl_out <= 1'b0;
    tick(2);
  endtask
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(b[i], r);
    bit_io(1'b1, ack);
  endtask
  // last byte of a read gets a not-acknowledge
  task automatic recv_byte(input logic nack, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, b[i]);
    bit_io(nack, r);
  endtask
endmodule

/* File: sim/test_cogsc_top.sv */
// self-checking bench for the clock gating and config slave block
// assumes the controller model stands on the two-wire side
module test_cogsc_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_in;
  logic        reset_n_in;
  logic        pg_pin;
  logic        spread_pin;
  logic [3:0]  oe_pins;
  logic        scl;
  wire logic   sda;
  logic        sda_drv;
  logic        sda_oe;
  logic [3:0]  outs;
  logic        spread_en;
  logic        osc_en;
  int          fail_count;
  int          tests_run;
  integer      seed;
  logic [3:0]  act;
  logic [7:0]  v;
  logic [7:0]  w;
  logic        nak;

  cogsc_top #(.REF_HALF(2)) i_cogsc_top (
    .clk_in                         (clk_in),
    .reset_n_in                     (reset_n_in),
    .power_good_or_powerdown_pin_in (pg_pin),
    .spread_select_input_in         (spread_pin),
    .oe_pins_in                     (oe_pins),
    .scl_in                         (scl),
    .sda_in                         (sda),
    .sda_out_out                    (sda_drv),
    .sda_oe_out                     (sda_oe),
    .differential_clock_outputs_out (outs),
    .spread_enable_out              (spread_en),
    .osc_enable_out                 (osc_en)
  );
  cogsc_host i_cogsc_host (
    .clk_in     (clk_in),
    .dev_oe_in  (sda_oe),
    .dev_out_in (sda_drv),
    .scl_out    (scl),
    .sda_out    (sda)
  );

  always #50 clk_in = ~clk_in;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // pin and register bit both needed; out0..3 sit at bits 4,2,1,0
  function automatic logic [3:0] exp_en(input logic [7:0] r, input logic [3:0] p);
    return p & {r[0], r[1], r[2], r[4]};
  endfunction
  task automatic hdr(input logic [7:0] cmd, input logic rd, output logic n);
    logic a;
    i_cogsc_host.start_cond();
    i_cogsc_host.send_byte(8'hd6, a);
    n = a;
    i_cogsc_host.send_byte(cmd, a);
    n = n | a;
    if (rd)
    begin
      i_cogsc_host.start_cond();
      i_cogsc_host.send_byte(8'hd7, a);
      n = n | a;
    end
  endtask
  task automatic wr(input logic [7:0] cmd, input logic [7:0] d);
    logic n;
    logic a;
    hdr(cmd, 1'b0, n);
    i_cogsc_host.send_byte(d, a);
    check({n, a}, 32'h0);
    i_cogsc_host.stop_cond();
  endtask
  // reads n bytes, expected packed first byte uppermost
  task automatic rd_chk(input logic [7:0] cmd, input int n, input logic [23:0] e);
    logic k;
    logic [7:0] b;
    hdr(cmd, 1'b1, k);
    check(k, 32'h0);
    for (int i = 0; i < n; i++)
    begin
      i_cogsc_host.recv_byte(i == n - 1, b);
      check(b, e[23 - 8 * i -: 8]);
    end
    i_cogsc_host.stop_cond();
  endtask
  // sampled on the falling edge, away from register updates
  task automatic watch(output logic [3:0] a);
    logic [3:0] prev;
    a = 4'h0;
    @(negedge clk_in);
    prev = outs;
    repeat (16)
    begin
      @(negedge clk_in);
      a = a | (outs ^ prev);
      prev = outs;
    end
  endtask

  initial
  begin
    repeat (60000) @(posedge clk_in);
    fail_count++;
    complete_run();
  end

  initial
  begin
    seed = 32'h1e2cbe8a;
    clk_in = 1'b0;
    reset_n_in = 1'b0;
    pg_pin = 1'b0;
    spread_pin = 1'b0;
    oe_pins = 4'hf;
    fail_count = 0;
    tests_run = 0;
    repeat (4) @(posedge clk_in);
    reset_n_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    // power-good still low: slave alive, outputs off
    rd_chk(8'h80, 1, 24'h000000);
    rd_chk(8'h81, 1, 24'h170000);
    rd_chk(8'h84, 1, 24'h060000);
    rd_chk(8'h00, 3, 24'h060017);
    watch(act);
    check({act, outs, osc_en}, 32'h01);
    $display("test power_good_low done");
    @(posedge clk_in);
    pg_pin <= 1'b1;
    repeat (40) @(posedge clk_in);
    watch(act);
    check(act, 32'hf);
    $display("test power_good_high done");
    // random enables, corner with only a reserved bit set
    for (int i = 0; i < 6; i++)
    begin
      v = (i == 0) ? 8'h08 : 8'($random(seed));
      @(posedge clk_in);
      oe_pins <= 4'($random(seed));
      wr(8'h81, v);
      rd_chk(8'h81, 1, {v, 16'h0});
      repeat (40) @(posedge clk_in);
      watch(act);
      check(act, exp_en(v, oe_pins));
      check(outs & ~exp_en(v, oe_pins), 32'h0);
    end
    $display("test output_enables done");
    v = 8'($random(seed));
    w = 8'($random(seed)) | 8'h17;
    hdr(8'h00, 1'b0, nak);
    check(nak, 32'h0);
    i_cogsc_host.send_byte(8'h02, nak);
    i_cogsc_host.send_byte(v, nak);
    i_cogsc_host.send_byte(w, nak);
    check(nak, 32'h0);
    i_cogsc_host.stop_cond();
    rd_chk(8'h00, 3, {8'h06, v, w});
    rd_chk(8'h82, 1, 24'h000000);
    $display("test block_transfers done");
    for (int i = 0; i < 2; i++)
    begin
      i_cogsc_host.start_cond();
      i_cogsc_host.send_byte(i == 0 ? 8'hd4 : 8'h56, nak);
      i_cogsc_host.send_byte(8'h00, nak);
      check({nak, sda_oe, sda_drv}, 32'h4);
      i_cogsc_host.stop_cond();
    end
    rd_chk(8'h80, 1, {v, 16'h0});
    $display("test foreign_address done");
    oe_pins <= 4'hf;
    wr(8'h81, 8'h17);
    @(posedge clk_in);
    pg_pin <= 1'b0;
    repeat (40) @(posedge clk_in);
    watch(act);
    check({act, outs, osc_en}, 32'h00);
    hdr(8'h81, 1'b1, nak);
    check(nak, 32'h1);
    i_cogsc_host.stop_cond();
    pg_pin <= 1'b1;
    repeat (40) @(posedge clk_in);
    watch(act);
    check({act, osc_en}, 32'h1f);
    $display("test power_down done");
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clk_in);
      spread_pin <= (i == 0) ? 1'b1 : 1'($random(seed));
      repeat (6) @(posedge clk_in);
      check(spread_en, spread_pin);
    end
    $display("test spread_select done");
    // second power-up: written values must fall back to defaults
    wr(8'h80, 8'hff);
    @(posedge clk_in);
    reset_n_in <= 1'b0;
    repeat (4) @(posedge clk_in);
    reset_n_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    rd_chk(8'h00, 3, 24'h060017);
    $display("test reset_defaults done");
    complete_run();
  end
endmodule
